// File: hw/acs_pkg.sv
// package: constants and carrier types for the channel scan sequencer
package acs_pkg;
  // register addresses on the internal write port
  localparam logic [3:0] ADDR_PRIMARY_CONFIG_REGISTER = 4'h1;
  localparam logic [3:0] ADDR_CONFIG1 = 4'h2;
  localparam logic [3:0] ADDR_CONFIG2 = 4'h3;
  localparam logic [3:0] ADDR_CONFIG3 = 4'h4;
  localparam logic [3:0] ADDR_IRQ = 4'h5;
  localparam logic [3:0] ADDR_MUX = 4'h6;
  localparam logic [3:0] ADDR_SCAN = 4'h7;
  localparam logic [3:0] ADDR_TIMER = 4'h8;
  localparam logic [3:0] ADDR_OFFCAL = 4'h9;
  localparam logic [3:0] ADDR_GAINCAL = 4'hA;
  // configuration register field positions
  localparam int OPMODE_LSB = 0;
  localparam int CONVMODE_LSB = 6;
  localparam int PRE_LSB = 6;
  localparam int OSR_LSB = 2;
  localparam int GAIN_LSB = 3;
  localparam int AZ_BIT = 2;
  localparam int ZC_EN_BIT = 1;
  localparam int SC_EN_BIT = 0;
  localparam int IRQMODE_LSB = 2;
  // scan register layout
  localparam int WAIT_LSB = 21;
  localparam logic [15:0] MASK_2CH = 16'hF103;
  localparam logic [15:0] MASK_4CH = 16'hF30F;
  localparam logic [15:0] MASK_8CH = 16'hFFFF;
  // operating and conversion mode codes
  localparam logic [1:0] MODE_SHDN = 2'h0;
  localparam logic [1:0] MODE_STBY = 2'h2;
  localparam logic [1:0] MODE_CONV = 2'h3;
  localparam logic [1:0] CONV_CONT = 2'h3;
  // forced channel settings
  localparam logic [7:0] MUX_SUPPLY = 8'h98;
  localparam logic [7:0] MUX_TEMP = 8'hDE;
  localparam logic [7:0] MUX_ZERO = 8'h88;
  localparam logic [7:0] MUX_COMMON = 8'hF8;
  localparam logic [2:0] GAIN_THIRD = 3'h0;
  localparam logic [2:0] GAIN_ONE = 3'h1;
  // timing counts
  localparam int SETUP_DECIMATOR_CLOCK = 256;
  localparam logic [23:0] SETUP_CNT = 24'h000100;
  localparam int RESTART_MCLK = 2;
  localparam logic [1:0] RESTART_CNT = 2'(RESTART_MCLK);
  // write strobe from the serial front end
  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [23:0] data;
  } acs_wr_t;
  // analog control toward the converter
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] mux;
    logic [2:0] gain;
    logic       short_gnd;
  } acs_ana_t;
endpackage : acs_pkg

// File: hw/acs_sequencer.sv
// module: scan sequencer with restart decision logic
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module acs_sequencer #(
  parameter logic [15:0] CHAN_MASK = acs_pkg::MASK_8CH
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic DECIMATOR_CLOCK_TICK_I,
  input wire acs_pkg::acs_wr_t WR_I,
  input wire logic CONV_DONE_I,
  output acs_pkg::acs_ana_t ANA_O,
  output logic CONV_RESET_O,
  output logic CONV_START_O,
  output logic SCAN_ACTIVE_O,
  output logic [3:0] CHAN_ID_O,
  output logic [1:0] MODE_RD_O,
  output logic [23:0] SCAN_RD_O,
  output logic [23:0] TIMER_RD_O
);

  typedef enum logic [2:0] {
    ACS_IDLE, ACS_CONV, ACS_WAIT, ACS_GAP, ACS_SINGLE
  } acs_state_t;

  //////////////////////////////////////////////////////////////////////////
  // register storage
  logic [1:0] op_mode_r;      // visible operating mode
  logic [1:0] conv_mode_r;    // one-shot or continuous
  logic [1:0] pre_r;          // prescaler
  logic [3:0] osr_r;          // oversampling ratio
  logic [2:0] gain_r;         // programmed gain
  logic az_r;                 // auto-zero chopping
  logic zc_en_r;              // zero correction enable
  logic sc_en_r;              // scale correction enable
  logic [1:0] irq_mode_r;     // interrupt mode
  logic [7:0] mux_r;          // single-channel selection
  logic [23:0] scan_r;        // scan config: wait and mask
  logic [23:0] timer_r;       // cycle interval count
  logic [1:0] int_mode_r;     // internal mode, hidden
  acs_state_t state_r;        // sequencer state
  logic [3:0] chan_r;         // channel in conversion
  logic [23:0] cnt_r;         // wait and interval counter
  logic [1:0] rst_cnt_r;      // restart delay counter
  logic cycle_restart_r;      // pending restart is a whole cycle

  logic [15:0] mask;          // usable enabled channels
  logic scan_mode;
  logic wr;
  logic [1:0] w_op;
  logic [23:0] d;
  logic restart_conv;
  logic restart_cycle;
  logic stop;
  logic [9:0] wait_len;
  logic [3:0] next_chan;
  logic has_next;
  logic [3:0] first_chan;

  assign d = WR_I.data;
  assign wr = WR_I.valid;
  assign w_op = d[acs_pkg::OPMODE_LSB +: 2];
  assign mask = scan_r[15:0] & CHAN_MASK;
  assign scan_mode = |mask;

  //////////////////////////////////////////////////////////////////////////
  // wait length decode
  always_comb begin
    unique case (scan_r[acs_pkg::WAIT_LSB +: 3])
      3'h0: wait_len = 10'h000;
      3'h1: wait_len = 10'h008;
      3'h2: wait_len = 10'h010;
      3'h3: wait_len = 10'h020;
      3'h4: wait_len = 10'h040;
      3'h5: wait_len = 10'h080;
      3'h6: wait_len = 10'h100;
      3'h7: wait_len = 10'h200;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // priority search: next enabled channel below current, and first
  always_comb begin
    next_chan = 4'h0;
    has_next = 1'b0;
    first_chan = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (mask[i]) begin
        first_chan = 4'(i);
      end
      if (mask[i] && (4'(i) < chan_r)) begin
        next_chan = 4'(i);
        has_next = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write classification: which writes restart what
  always_comb begin
    restart_conv = 1'b0;
    restart_cycle = 1'b0;
    stop = 1'b0;
    if (wr) begin
      unique case (WR_I.addr)
        acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER: begin
          if (w_op == acs_pkg::MODE_CONV) begin
            restart_cycle = 1'b1;
          end else begin
            stop = 1'b1;
          end
        end
        acs_pkg::ADDR_CONFIG1, acs_pkg::ADDR_CONFIG2: begin
          restart_conv = 1'b1;
        end
        acs_pkg::ADDR_CONFIG3: begin
          // enables restart only on change; other bits are digital
          restart_conv = (d[acs_pkg::ZC_EN_BIT] != zc_en_r) ||
                         (d[acs_pkg::SC_EN_BIT] != sc_en_r);
        end
        acs_pkg::ADDR_IRQ: begin
          restart_conv = d[acs_pkg::IRQMODE_LSB +: 2] != irq_mode_r;
        end
        acs_pkg::ADDR_MUX: begin
          restart_conv = !scan_mode;
        end
        acs_pkg::ADDR_SCAN: begin
          // wait field alone is ignored out of scan
          if (scan_mode) begin
            restart_cycle = (state_r != ACS_GAP);
          end else begin
            restart_cycle = |(d[15:0] & CHAN_MASK);
          end
        end
        acs_pkg::ADDR_TIMER: begin
          restart_cycle = scan_mode && (state_r == ACS_GAP);
        end
        acs_pkg::ADDR_OFFCAL: begin
          restart_conv = zc_en_r;
        end
        acs_pkg::ADDR_GAINCAL: begin
          restart_conv = sc_en_r;
        end
        default: begin
          // no restart for unmapped or digital-only writes
          restart_conv = 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register writes; digital fields just store
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      op_mode_r <= 2'h0;
      conv_mode_r <= 2'h0;
      pre_r <= 2'h0;
      osr_r <= 4'h3;
      gain_r <= acs_pkg::GAIN_ONE;
      az_r <= 1'b0;
      zc_en_r <= 1'b0;
      sc_en_r <= 1'b0;
      irq_mode_r <= 2'h0;
      mux_r <= 8'h01;
      scan_r <= 24'h000000;
      timer_r <= 24'h000000;
    end else if (wr) begin
      unique case (WR_I.addr)
        acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER: op_mode_r <= w_op;
        acs_pkg::ADDR_CONFIG1: begin
          pre_r <= d[acs_pkg::PRE_LSB +: 2];
          osr_r <= d[acs_pkg::OSR_LSB +: 4];
        end
        acs_pkg::ADDR_CONFIG2: begin
          gain_r <= d[acs_pkg::GAIN_LSB +: 3];
          az_r <= d[acs_pkg::AZ_BIT];
        end
        acs_pkg::ADDR_CONFIG3: begin
          conv_mode_r <= d[acs_pkg::CONVMODE_LSB +: 2];
          zc_en_r <= d[acs_pkg::ZC_EN_BIT];
          sc_en_r <= d[acs_pkg::SC_EN_BIT];
        end
        acs_pkg::ADDR_IRQ: irq_mode_r <= d[acs_pkg::IRQMODE_LSB +: 2];
        acs_pkg::ADDR_MUX: mux_r <= d[7:0];
        acs_pkg::ADDR_SCAN: begin
          scan_r <= {d[23:16], d[15:0] & CHAN_MASK};
        end
        acs_pkg::ADDR_TIMER: timer_r <= d;
        default: op_mode_r <= op_mode_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // restart delay: reset now, start two master clocks later
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_cnt_r <= 2'h0;
      cycle_restart_r <= 1'b0;
    end else if (stop) begin
      rst_cnt_r <= 2'h0;
      cycle_restart_r <= 1'b0;
    end else if (restart_cycle || restart_conv) begin
      rst_cnt_r <= acs_pkg::RESTART_CNT;
      cycle_restart_r <= restart_cycle || cycle_restart_r;
    end else if (rst_cnt_r != 2'h0) begin
      rst_cnt_r <= rst_cnt_r - 2'h1;
    end else begin
      cycle_restart_r <= 1'b0;
    end
  end

  assign CONV_RESET_O = restart_conv || restart_cycle || stop;
  assign CONV_START_O = (rst_cnt_r == 2'h1) &&
                        (op_mode_r == acs_pkg::MODE_CONV);

  //////////////////////////////////////////////////////////////////////////
  // scan state machine
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= ACS_IDLE;
      chan_r <= 4'h0;
      cnt_r <= 24'h000000;
      int_mode_r <= acs_pkg::MODE_SHDN;
    end else if (stop) begin
      state_r <= ACS_IDLE;
      int_mode_r <= w_op;
    end else if (CONV_START_O) begin
      if (cycle_restart_r || state_r == ACS_IDLE) begin
        // whole cycle restarts from highest channel
        state_r <= scan_mode ? ACS_CONV : ACS_SINGLE;
        chan_r <= scan_mode ? first_chan : 4'h0;
        int_mode_r <= acs_pkg::MODE_CONV;
      end else if (state_r == ACS_WAIT || state_r == ACS_GAP) begin
        // parked between conversions: keep standby or shutdown
        state_r <= state_r;
      end else begin
        state_r <= state_r;
        int_mode_r <= acs_pkg::MODE_CONV;
      end
    end else if (rst_cnt_r != 2'h0) begin
      state_r <= state_r;
    end else begin
      unique case (state_r)
        ACS_IDLE, ACS_SINGLE: state_r <= state_r;
        ACS_CONV: begin
          if (CONV_DONE_I) begin
            if (has_next) begin
              chan_r <= next_chan;
              if (wait_len != 10'h000) begin
                state_r <= ACS_WAIT;
                cnt_r <= {14'h0000, wait_len};
                int_mode_r <= acs_pkg::MODE_STBY;
              end
            end else if (conv_mode_r == acs_pkg::CONV_CONT) begin
              state_r <= ACS_GAP;
              chan_r <= first_chan;
              cnt_r <= timer_r;
              int_mode_r <= (timer_r > acs_pkg::SETUP_CNT) ?
                acs_pkg::MODE_SHDN : acs_pkg::MODE_STBY;
            end else begin
              state_r <= ACS_IDLE;
              int_mode_r <= acs_pkg::MODE_STBY;
            end
          end
        end
        ACS_WAIT: begin
          if (DECIMATOR_CLOCK_TICK_I) begin
            if (cnt_r <= 24'h000001) begin
              state_r <= ACS_CONV;
              int_mode_r <= acs_pkg::MODE_CONV;
            end else begin
              cnt_r <= cnt_r - 24'h000001;
            end
          end
        end
        ACS_GAP: begin
          if (cnt_r == 24'h000000) begin
            state_r <= ACS_CONV;
            int_mode_r <= acs_pkg::MODE_CONV;
          end else if (DECIMATOR_CLOCK_TICK_I) begin
            cnt_r <= cnt_r - 24'h000001;
            if (cnt_r == acs_pkg::SETUP_CNT + 24'h000001) begin
              int_mode_r <= acs_pkg::MODE_STBY;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // analog control with forced internal channels
  always_comb begin
    ANA_O.mode = int_mode_r;
    ANA_O.mux = mux_r;
    ANA_O.gain = gain_r;
    ANA_O.short_gnd = 1'b0;
    if (scan_mode) begin
      unique case (chan_r)
        4'hF: begin
          ANA_O.mux = acs_pkg::MUX_ZERO;
          ANA_O.short_gnd = 1'b1;
        end
        4'hE: begin
          ANA_O.mux = acs_pkg::MUX_COMMON;
          ANA_O.gain = acs_pkg::GAIN_ONE;
        end
        4'hD: begin
          ANA_O.mux = acs_pkg::MUX_SUPPLY;
          ANA_O.gain = acs_pkg::GAIN_THIRD;
        end
        4'hC: begin
          ANA_O.mux = acs_pkg::MUX_TEMP;
          ANA_O.gain = acs_pkg::GAIN_ONE;
        end
        4'hB: ANA_O.mux = 8'h67;
        4'hA: ANA_O.mux = 8'h45;
        4'h9: ANA_O.mux = 8'h23;
        4'h8: ANA_O.mux = 8'h01;
        default: ANA_O.mux = {1'b0, chan_r[2:0], 4'h8};
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // readback
  assign MODE_RD_O = op_mode_r;
  assign SCAN_RD_O = scan_r;
  assign TIMER_RD_O = timer_r;
  assign SCAN_ACTIVE_O = scan_mode && (state_r != ACS_IDLE);
  assign CHAN_ID_O = chan_r;

endmodule : acs_sequencer

// File: bench/acs_checker.sv
// checker: port-level properties of the scan sequencer
`timescale 1ns/1ps
module acs_checker #(
  parameter logic [15:0] CHAN_MASK = acs_pkg::MASK_8CH
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic DECIMATOR_CLOCK_TICK_I,
  input wire acs_pkg::acs_wr_t WR_I,
  input wire logic CONV_DONE_I,
  input wire acs_pkg::acs_ana_t ANA_O,
  input wire logic CONV_RESET_O,
  input wire logic CONV_START_O,
  input wire logic SCAN_ACTIVE_O,
  input wire logic [3:0] CHAN_ID_O,
  input wire logic [1:0] MODE_RD_O,
  input wire logic [23:0] SCAN_RD_O,
  input wire logic [23:0] TIMER_RD_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // a scan conversion is in progress
  wire logic conv = SCAN_ACTIVE_O && ANA_O.mode == acs_pkg::MODE_CONV;
  //////////////////////////////////////////////////////////////////////////
  // restart steps: reset, a quiet cycle, then mode still converting
  sequence s_rst_arm;
    CONV_RESET_O ##1 !CONV_RESET_O;
  endsequence
  sequence s_mode_on;
    !CONV_RESET_O && MODE_RD_O == acs_pkg::MODE_CONV;
  endsequence
  restart_delay_a: assert property (
    s_rst_arm ##1 s_mode_on |-> CONV_START_O)
    else $error("start not two clocks after reset");
  start_cause_a: assert property (
    CONV_START_O |-> $past(CONV_RESET_O, 2))
    else $error("start without earlier reset");
  mode_restart_a: assert property (
    WR_I.valid && WR_I.addr == acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER &&
    WR_I.data[1:0] == acs_pkg::MODE_CONV |-> CONV_RESET_O)
    else $error("mode write did not reset");
  mode_reads_a: assert property (
    SCAN_ACTIVE_O |-> MODE_RD_O == acs_pkg::MODE_CONV)
    else $error("mode field not read as converting");
  //////////////////////////////////////////////////////////////////////////
  // forced channel settings
  supply_force_a: assert property (
    conv && CHAN_ID_O == 4'hD |-> ANA_O.mux == acs_pkg::MUX_SUPPLY &&
    ANA_O.gain == acs_pkg::GAIN_THIRD)
    else $error("supply channel settings wrong");
  temp_force_a: assert property (
    conv && CHAN_ID_O == 4'hC |-> ANA_O.mux == acs_pkg::MUX_TEMP &&
    ANA_O.gain == acs_pkg::GAIN_ONE)
    else $error("temperature channel settings wrong");
  zero_short_a: assert property (
    conv && CHAN_ID_O == 4'hF |-> ANA_O.short_gnd)
    else $error("zero channel not shorted");
  common_force_a: assert property (
    conv && CHAN_ID_O == 4'hE |-> ANA_O.mux == acs_pkg::MUX_COMMON &&
    ANA_O.gain == acs_pkg::GAIN_ONE)
    else $error("common channel settings wrong");
  //////////////////////////////////////////////////////////////////////////
  // mask handling and ignored writes
  mask_drop_a: assert property (
    (SCAN_RD_O[15:0] & ~CHAN_MASK) == 16'h0000)
    else $error("unavailable mask bit stored");
  scan_enable_a: assert property (
    (SCAN_RD_O[15:0] == 16'h0000) [*2] |-> !SCAN_ACTIVE_O)
    else $error("scan active with empty mask");
  mux_ignored_a: assert property (
    WR_I.valid && WR_I.addr == acs_pkg::ADDR_MUX &&
    SCAN_RD_O[15:0] != 16'h0000 |-> !CONV_RESET_O)
    else $error("mux write restarted in scan");
endmodule : acs_checker
bind acs_sequencer acs_checker #(.CHAN_MASK(CHAN_MASK)) i_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .DECIMATOR_CLOCK_TICK_I(DECIMATOR_CLOCK_TICK_I),
  .WR_I(WR_I), .CONV_DONE_I(CONV_DONE_I), .ANA_O(ANA_O),
  .CONV_RESET_O(CONV_RESET_O), .CONV_START_O(CONV_START_O),
  .SCAN_ACTIVE_O(SCAN_ACTIVE_O), .CHAN_ID_O(CHAN_ID_O),
  .MODE_RD_O(MODE_RD_O), .SCAN_RD_O(SCAN_RD_O), .TIMER_RD_O(TIMER_RD_O)
);

// File: bench/acs_host_model.sv
// host model: register write strobes plus a converter stub
`timescale 1ns/1ps
module acs_host_model #(
  parameter int CONV_CYC = 20 // cycles per conversion, arbitrary
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire acs_pkg::acs_ana_t ana_i,
  input wire logic conv_reset_i,
  output acs_pkg::acs_wr_t wr_o,
  output logic done_o
);
  int run_r; // cycles spent converting
  // idle bus at time zero
  initial begin
    wr_o = '0;
  end
  // one strobe, held until the edge that takes it
  task automatic write(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_i);
    wr_o <= '{1'b1, a, d};
    @(posedge clk_i);
    wr_o.valid <= 1'b0;
  endtask : write
  // conversion ends after a run of converting cycles; reset restarts it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_r <= 0;
      done_o <= 1'b0;
    end else if (conv_reset_i || ana_i.mode != acs_pkg::MODE_CONV) begin
      run_r <= 0;
      done_o <= 1'b0;
    end else begin
      run_r <= (run_r == CONV_CYC - 1) ? 0 : run_r + 1;
      done_o <= (run_r == CONV_CYC - 1);
    end
  end
endmodule : acs_host_model

// File: bench/adc_channel_sequencer_restart_tb_top.sv
// testbench: write sequences against the scan sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module adc_channel_sequencer_restart_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, done;
  logic c_rst, c_start, active, collect = 1'b0, stby, shdn, rd_bad;
  acs_pkg::acs_wr_t wr;
  acs_pkg::acs_ana_t ana;
  logic [3:0] chan;
  logic [1:0] mode_rd;
  logic [23:0] scan_rd, timer_rd;
  int error_cnt = 0, num_checks = 0, rst_cnt = 0, start_cnt = 0;
  logic [3:0] ids[$]; // channel at each finished conversion
  localparam logic [3:0] EXP_IDS [5] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'h9};
  localparam logic [23:0] OFS = 24'h000010; // measured offset
  int tmr [3] = '{10, 256, 300};
  logic shdn_exp [3] = '{1'b0, 1'b0, 1'b1};
  always #5 clk = ~clk;
  // decimator tick every second clock
  always @(posedge clk) tick <= ~tick;
  // pulse counters and scan observation
  always @(posedge clk) begin
    if (c_rst === 1'b1) rst_cnt++;
    if (c_start === 1'b1) start_cnt++;
    if (collect && done === 1'b1) ids.push_back(chan);
    if (collect && ana.mode === acs_pkg::MODE_STBY) stby = 1'b1;
    if (collect && ana.mode === acs_pkg::MODE_SHDN) shdn = 1'b1;
    if (collect && mode_rd !== acs_pkg::MODE_CONV) rd_bad = 1'b1;
  end
  acs_sequencer #(.CHAN_MASK(acs_pkg::MASK_4CH)) i_dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .DECIMATOR_CLOCK_TICK_I(tick), .WR_I(wr),
    .CONV_DONE_I(done), .ANA_O(ana), .CONV_RESET_O(c_rst),
    .CONV_START_O(c_start), .SCAN_ACTIVE_O(active), .CHAN_ID_O(chan),
    .MODE_RD_O(mode_rd), .SCAN_RD_O(scan_rd), .TIMER_RD_O(timer_rd)
  );
  acs_host_model i_host (
    .clk_i(clk), .rst_n_i(rst_n), .ana_i(ana), .conv_reset_i(c_rst),
    .wr_o(wr), .done_o(done)
  );
  // verdict and end of run
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // write, then count resets and starts it caused
  task automatic wr_chk(input logic [3:0] a, input logic [23:0] d, int n);
    int r0, s0;
    r0 = rst_cnt;
    s0 = start_cnt;
    i_host.write(a, d);
    repeat (3) @(posedge clk);
    `CHK(rst_cnt - r0, n)
    `CHK(start_cnt - s0, n)
  endtask : wr_chk
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(mode_rd, acs_pkg::MODE_SHDN)
    `CHK(scan_rd, 24'h000000)
    `CHK(timer_rd, 24'h000000)
    `CHK(ana.gain, acs_pkg::GAIN_ONE)
    `CHK(ana.mux, 8'h01)
    wr_chk(acs_pkg::ADDR_CONFIG3, 24'h0000C0, 0);
    wr_chk(acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER, 24'h000003, 1);
    wr_chk(acs_pkg::ADDR_CONFIG3, 24'h0000C2, 1);
    wr_chk(acs_pkg::ADDR_CONFIG3, 24'h0000C2, 0);
    wr_chk(acs_pkg::ADDR_OFFCAL, -OFS, 1);
    wr_chk(acs_pkg::ADDR_CONFIG3, 24'h0000C0, 1);
    wr_chk(acs_pkg::ADDR_OFFCAL, OFS, 0);
    wr_chk(acs_pkg::ADDR_IRQ, 24'h000004, 1);
    wr_chk(acs_pkg::ADDR_IRQ, 24'h000005, 0);
    wr_chk(acs_pkg::ADDR_CONFIG2, 24'h000010, 1);
    wr_chk(acs_pkg::ADDR_SCAN, 24'hE00000, 0);
    wr_chk(acs_pkg::ADDR_MUX, 24'h000023, 1);
    `CHK(ana.mux, 8'h23)
    wr_chk(acs_pkg::ADDR_TIMER, 24'hFFFFFF, 0);
    `CHK(timer_rd, 24'hFFFFFF)
    i_host.write(acs_pkg::ADDR_SCAN, 24'h20FE00);
    @(posedge clk);
    `CHK(scan_rd, 24'h20F200)
    // one run per cycle interval: short, equal to setup, long
    for (int k = 0; k < 3; k++) begin
      collect <= 1'b0;
      i_host.write(acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER, 24'h000000);
      @(posedge clk);
      `CHK(mode_rd, acs_pkg::MODE_SHDN)
      `CHK(active, 1'b0)
      i_host.write(acs_pkg::ADDR_TIMER, 24'(tmr[k]));
      ids.delete();
      stby = 1'b0;
      shdn = 1'b0;
      rd_bad = 1'b0;
      i_host.write(acs_pkg::ADDR_PRIMARY_CONFIG_REGISTER, 24'h000003);
      // watch only once the restarted cycle has begun converting
      repeat (2) @(posedge clk);
      collect <= 1'b1;
      for (int n = 0; n < 3000 && ids.size() < 1; n++) @(posedge clk);
      if (k == 0) begin
        i_host.write(acs_pkg::ADDR_CONFIG2, 24'h000008);
        i_host.write(acs_pkg::ADDR_MUX, 24'h000045);
      end
      for (int n = 0; n < 8000 && ids.size() < 10; n++) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
        `CHK(ids[i], EXP_IDS[i % 5])
      end
      `CHK(ids.size() >= 10, 1'b1)
      `CHK(active, 1'b1)
      `CHK(stby, 1'b1)
      `CHK(shdn, shdn_exp[k])
      `CHK(rd_bad, 1'b0)
    end
    summarize();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : adc_channel_sequencer_restart_tb_top
